// ===== logic/uls_line_status.sv
// Serial port line status logic with its receiver, receive FIFO, transmitter and interrupt.
// Assumes a register master on the same clock: one-cycle strobes, read data next cycle.
// Behaviour
// [R1] Card error after retry limit plus one nacks
// [R2] Errored character stored sets FIFO error flag
// [R3] FIFO error clears on read if none left
// [R4] All-empty only when holding and shift empty
// [R5] Holding empty sets when shift register loads
// [R6] Holding empty clears on CPU character write
// [R7] Holding empty interrupt while flag and enable
// [R8] Full all-zero character flags a break
// [R9] After break, wait for line high
// [R10] Low stop bit flags framing error
// [R11] Bad stop bit taken as next start
// [R12] Wrong parity bit flags parity error
// [R13] Status read clears break, framing, parity, overrun
// [R14] Overrun set when character arrives, FIFO full
// [R15] Overrun keeps FIFO, drops new character
// [R16] Data available while FIFO not empty
// [R17] Character errors reported for FIFO head
// [R18] Error visibility timing follows FIFO enable
// [R19] Read returns pre-clear values, set wins
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module uls_line_status (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire uls_pkg::uls_bus_req_t i_bus,
	output logic [31:0] o_rdata,
	input wire logic i_rx_serial_in,
	output logic o_tx_serial_out,
	input wire logic i_card_nack,
	output logic o_tx_holding_empty_irq,
	output logic o_irq
);
	// ****************************************
	// Package constants
	// ****************************************
	// Short local names for package values; the values themselves live only in the package
	localparam int ULS_IRQ_W = uls_pkg::ULS_IRQ_W, ULS_LS_W = uls_pkg::ULS_LS_W;
	localparam int ULS_FIFO_DEPTH = uls_pkg::ULS_FIFO_DEPTH, ULS_FIFO_AW = uls_pkg::ULS_FIFO_AW;
	localparam int ULS_CTL_FIFO_EN = uls_pkg::ULS_CTL_FIFO_EN, ULS_CTL_PAR_EN = uls_pkg::ULS_CTL_PAR_EN;
	localparam int ULS_CTL_PAR_ODD = uls_pkg::ULS_CTL_PAR_ODD, ULS_CTL_CARD_EN = uls_pkg::ULS_CTL_CARD_EN;
	localparam int ULS_CTL_TX_HOLDING_EMPTY_IE = uls_pkg::ULS_CTL_TX_HOLDING_EMPTY_IE, ULS_CTL_RETRY_LSB = uls_pkg::ULS_CTL_RETRY_LSB;
	localparam int ULS_CTL_DIV_LSB = uls_pkg::ULS_CTL_DIV_LSB;
	localparam int ULS_LS_RDA = uls_pkg::ULS_LS_RDA, ULS_LS_THE = uls_pkg::ULS_LS_THE;
	localparam int ULS_LS_TAE = uls_pkg::ULS_LS_TAE, ULS_LS_CTE = uls_pkg::ULS_LS_CTE;
	localparam logic [7:0] ULS_ADDR_DATA = uls_pkg::ULS_ADDR_DATA, ULS_ADDR_CTRL = uls_pkg::ULS_ADDR_CTRL;
	localparam logic [7:0] ULS_ADDR_IRQ_STAT = uls_pkg::ULS_ADDR_IRQ_STAT;
	localparam logic [7:0] ULS_ADDR_IRQ_MASK = uls_pkg::ULS_ADDR_IRQ_MASK;
	localparam logic [7:0] ULS_ADDR_LINE_STATUS = uls_pkg::ULS_ADDR_LINE_STATUS;
	localparam logic [31:0] ULS_CTRL_RST = uls_pkg::ULS_CTRL_RST, ULS_CTRL_MASK = uls_pkg::ULS_CTRL_MASK;
	localparam logic [3:0] ULS_OVS_LAST = uls_pkg::ULS_OVS_LAST, ULS_OVS_MID = uls_pkg::ULS_OVS_MID;
	localparam logic [2:0] ULS_DATA_LAST = uls_pkg::ULS_DATA_LAST;
	localparam uls_pkg::uls_rx_state_t RX_IDLE = uls_pkg::RX_IDLE, RX_START = uls_pkg::RX_START;
	localparam uls_pkg::uls_rx_state_t RX_DATA = uls_pkg::RX_DATA, RX_PAR = uls_pkg::RX_PAR;
	localparam uls_pkg::uls_rx_state_t RX_STOP = uls_pkg::RX_STOP, RX_BRK = uls_pkg::RX_BRK;
	localparam uls_pkg::uls_tx_state_t TX_IDLE = uls_pkg::TX_IDLE, TX_START = uls_pkg::TX_START;
	localparam uls_pkg::uls_tx_state_t TX_DATA = uls_pkg::TX_DATA, TX_PAR = uls_pkg::TX_PAR;
	localparam uls_pkg::uls_tx_state_t TX_STOP = uls_pkg::TX_STOP;

	// ****************************************
	// Declarations
	// ****************************************
	logic [31:0] ctrl_r; // Control register
	logic [ULS_IRQ_W-1:0] irq_stat_r; // Sticky interrupt status
	logic [ULS_IRQ_W-1:0] irq_mask_r; // Interrupt mask
	logic [ULS_IRQ_W-1:0] irq_set; // Interrupt events this cycle
	logic [15:0] div_cnt_r; // Oversample divider
	logic tick; // One-cycle oversample enable
	logic [2:0] rx_sync_r; // Three-stage input synchroniser
	logic rx_level_r; // Filtered line level
	uls_pkg::uls_rx_state_t rx_state_r;
	logic [3:0] rx_ovs_r; // Ticks within a bit
	logic [2:0] rx_bit_r; // Data bit index
	logic [7:0] rx_shift_reg; // Receive shift register
	logic rx_par_r; // Received parity bit
	logic rx_zero_r; // Every bit so far low
	logic frame_done; // Stop bit sampled
	uls_pkg::uls_rx_entry_t rx_entry; // Character assembled this cycle
	uls_pkg::uls_rx_entry_t rx_buffer_fifo [ULS_FIFO_DEPTH]; // Receive FIFO storage
	logic [ULS_FIFO_AW-1:0] wr_ptr_r;
	logic [ULS_FIFO_AW-1:0] rd_ptr_r;
	logic [ULS_FIFO_AW:0] count_r; // Stored characters
	logic [ULS_FIFO_AW:0] err_cnt_r; // Stored characters carrying an error
	logic fifo_full;
	logic push_ok;
	logic pop;
	uls_pkg::uls_rx_entry_t head; // Entry at the FIFO head
	logic head_new; // A different entry becomes head
	uls_pkg::uls_rx_entry_t new_head;
	logic ls_read; // Line status read this cycle
	logic ovr_r, par_r, frm_r, brk_r, rfe_r, cte_r; // Line status flags
	logic [ULS_LS_W-1:0] ls_vec; // Line status as read
	logic [7:0] tx_holding_reg;
	logic thr_valid_r; // Holding register full
	logic thr_write; // CPU writes a character
	uls_pkg::uls_tx_state_t tx_state_r;
	logic [7:0] tx_shift_reg;
	logic [3:0] tx_ovs_r;
	logic [2:0] tx_bit_r;
	logic tx_par_r; // Parity of the character, set when the shift register loads
	logic tsr_load; // Holding register moves into shift register
	logic tx_holding_empty, tx_all_empty;
	logic [3:0] nack_cnt_r; // Card nacks for current character
	logic card_err_set;
	logic line_err_set;

	// Even parity of a byte, xor'd with the odd selection
	function automatic logic par_of(input logic [7:0] d, input logic odd);
		par_of = (^d) ^ odd;
	endfunction

	// ****************************************
	// Baud tick divider
	// ****************************************
	assign tick = (div_cnt_r == 16'h0000);
	// Divisor of zero behaves as one so the receiver never stalls
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || tick)
			div_cnt_r <= (ctrl_r[ULS_CTL_DIV_LSB +: 16] == 16'h0000) ? 16'h0000
				: ctrl_r[ULS_CTL_DIV_LSB +: 16] - 16'h0001;
		else
			div_cnt_r <= div_cnt_r - 16'h0001;
	end

	// ****************************************
	// Input synchroniser
	// ****************************************
	// A level counts only once the second and third stages agree
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rx_sync_r <= 3'h7;
			rx_level_r <= 1'b1;
		end
		else
		begin
			rx_sync_r <= {rx_sync_r[1:0], i_rx_serial_in};
			if (rx_sync_r[1] == rx_sync_r[2])
				rx_level_r <= rx_sync_r[2];
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	assign frame_done = tick && (rx_state_r == RX_STOP) && (rx_ovs_r == ULS_OVS_LAST);
	// Break needs every bit low including the stop bit
	assign rx_entry.bi = rx_zero_r && !rx_level_r; // [R8]
	assign rx_entry.fe = !rx_level_r && !rx_entry.bi; // [R10]
	assign rx_entry.pe = ctrl_r[ULS_CTL_PAR_EN] && !rx_entry.bi
		&& (rx_par_r != par_of(rx_shift_reg, ctrl_r[ULS_CTL_PAR_ODD])); // [R12]
	assign rx_entry.data = rx_shift_reg;

	// Sampling walks from mid start bit to mid of each later bit
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			rx_state_r <= RX_IDLE;
			rx_ovs_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_r <= 1'b0;
			rx_zero_r <= 1'b0;
		end
		else
		begin
			case (rx_state_r)
				RX_IDLE:
				begin
					rx_ovs_r <= 4'h0;
					if (!rx_level_r)
						rx_state_r <= RX_START;
				end
				RX_BRK:
				begin
					// Stay deaf until the line marks again
					if (rx_level_r) // [R9]
						rx_state_r <= RX_IDLE;
				end
				default:
				begin
					if (tick)
					begin
						rx_ovs_r <= rx_ovs_r + 4'h1;
						if (rx_state_r == RX_START && rx_ovs_r == ULS_OVS_MID)
						begin
							// A short glitch is not a start bit
							rx_ovs_r <= 4'h0;
							rx_bit_r <= 3'h0;
							rx_zero_r <= 1'b1;
							rx_state_r <= rx_level_r ? RX_IDLE : RX_DATA;
						end
						else if (rx_state_r != RX_START && rx_ovs_r == ULS_OVS_LAST)
						begin
							rx_zero_r <= rx_zero_r && !rx_level_r;
							case (rx_state_r)
								RX_DATA:
								begin
									rx_shift_reg <= {rx_level_r, rx_shift_reg[7:1]};
									rx_bit_r <= rx_bit_r + 3'h1;
									if (rx_bit_r == ULS_DATA_LAST)
										rx_state_r <= ctrl_r[ULS_CTL_PAR_EN] ? RX_PAR : RX_STOP;
								end
								RX_PAR:
								begin
									rx_par_r <= rx_level_r;
									rx_state_r <= RX_STOP;
								end
								default:
								begin
									if (rx_entry.bi)
										rx_state_r <= RX_BRK;
									else if (rx_entry.fe)
									begin
										// Bad stop bit is mid of a new start bit
										rx_state_r <= RX_DATA; // [R11]
										rx_bit_r <= 3'h0;
										rx_zero_r <= 1'b1;
									end
									else
										rx_state_r <= RX_IDLE;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// Receive FIFO
	// ****************************************
	// With the FIFO off it holds a single character
	assign fifo_full = ctrl_r[ULS_CTL_FIFO_EN] ? (count_r == 5'h10) : (count_r != 5'h00);
	assign push_ok = frame_done && !fifo_full; // [R15]
	assign pop = i_bus.rd && (i_bus.addr == ULS_ADDR_DATA) && (count_r != 5'h00);
	assign head = rx_buffer_fifo[rd_ptr_r];
	assign ls_read = i_bus.rd && (i_bus.addr == ULS_ADDR_LINE_STATUS);

	// Errors surface when their character reaches the head, so timing follows FIFO mode
	always_comb
	begin
		head_new = 1'b0;
		new_head = rx_entry;
		if (push_ok && (count_r == 5'h00 || (pop && count_r == 5'h01))) // [R18]
			head_new = 1'b1;
		else if (pop && count_r > 5'h01)
		begin
			head_new = 1'b1;
			new_head = rx_buffer_fifo[rd_ptr_r + 4'h1]; // [R17]
		end
	end

	// Storage has no reset; only the pointers matter
	always_ff @(posedge i_clk)
	begin
		if (push_ok)
			rx_buffer_fifo[wr_ptr_r] <= rx_entry;
	end

	// Pointers, occupancy and count of errored entries
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			wr_ptr_r <= 4'h0;
			rd_ptr_r <= 4'h0;
			count_r <= 5'h00;
			err_cnt_r <= 5'h00;
		end
		else
		begin
			if (push_ok)
				wr_ptr_r <= wr_ptr_r + 4'h1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 4'h1;
			count_r <= count_r + {4'h0, push_ok} - {4'h0, pop};
			err_cnt_r <= err_cnt_r + {4'h0, push_ok && (rx_entry.bi || rx_entry.fe || rx_entry.pe)}
				- {4'h0, pop && (head.bi || head.fe || head.pe)};
		end
	end

	// ****************************************
	// Line status flags
	// ****************************************
	assign ls_vec = {cte_r, rfe_r, tx_all_empty, tx_holding_empty, brk_r, frm_r, par_r, ovr_r,
		count_r != 5'h00}; // [R16]
	assign line_err_set = (frame_done && fifo_full) || (head_new && (new_head.bi || new_head.fe || new_head.pe));

	// Read clears after capture; a set in the same cycle wins
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ovr_r <= 1'b0;
			par_r <= 1'b0;
			frm_r <= 1'b0;
			brk_r <= 1'b0;
			rfe_r <= 1'b0;
			cte_r <= 1'b0;
		end
		else
		begin
			ovr_r <= (ovr_r && !ls_read) || (frame_done && fifo_full); // [R13] [R14] [R19]
			par_r <= (par_r && !ls_read) || (head_new && new_head.pe); // [R13] [R17]
			frm_r <= (frm_r && !ls_read) || (head_new && new_head.fe); // [R13] [R17]
			brk_r <= (brk_r && !ls_read) || (head_new && new_head.bi); // [R13] [R17]
			cte_r <= (cte_r && !ls_read) || card_err_set;
			if (!ctrl_r[ULS_CTL_FIFO_EN])
				rfe_r <= 1'b0; // [R3]
			else if (push_ok && (rx_entry.bi || rx_entry.fe || rx_entry.pe))
				rfe_r <= 1'b1; // [R2]
			else if (ls_read && err_cnt_r == 5'h00)
				rfe_r <= 1'b0; // [R3]
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	assign thr_write = i_bus.wr && (i_bus.addr == ULS_ADDR_DATA);
	assign tsr_load = (tx_state_r == TX_IDLE) && thr_valid_r;
	assign tx_holding_empty = !thr_valid_r; // [R5] [R6]
	assign tx_all_empty = !thr_valid_r && (tx_state_r == TX_IDLE); // [R4]

	// Holding register: a write fills it, a shift load drains it
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			thr_valid_r <= 1'b0;
			tx_holding_reg <= 8'h00;
		end
		else if (thr_write)
		begin
			thr_valid_r <= 1'b1; // [R6]
			tx_holding_reg <= i_bus.wdata[7:0];
		end
		else if (tsr_load)
			thr_valid_r <= 1'b0; // [R5]
	end

	// Shift register sends start, data, parity and stop, sixteen ticks each
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			tx_state_r <= TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_ovs_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_par_r <= 1'b0;
			o_tx_serial_out <= 1'b1;
		end
		else if (tsr_load)
		begin
			tx_state_r <= TX_START;
			tx_shift_reg <= tx_holding_reg;
			tx_par_r <= par_of(tx_holding_reg, ctrl_r[ULS_CTL_PAR_ODD]);
			tx_ovs_r <= 4'h0;
			tx_bit_r <= 3'h0;
			o_tx_serial_out <= 1'b0;
		end
		else if (tick && tx_state_r != TX_IDLE)
		begin
			tx_ovs_r <= tx_ovs_r + 4'h1;
			if (tx_ovs_r == ULS_OVS_LAST)
			begin
				case (tx_state_r)
					TX_START:
					begin
						tx_state_r <= TX_DATA;
						o_tx_serial_out <= tx_shift_reg[0];
					end
					TX_DATA:
					begin
						tx_bit_r <= tx_bit_r + 3'h1;
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						o_tx_serial_out <= tx_shift_reg[1];
						if (tx_bit_r == ULS_DATA_LAST)
						begin
							tx_state_r <= ctrl_r[ULS_CTL_PAR_EN] ? TX_PAR : TX_STOP;
							o_tx_serial_out <= ctrl_r[ULS_CTL_PAR_EN] ? tx_par_r : 1'b1;
						end
					end
					TX_PAR:
					begin
						tx_state_r <= TX_STOP;
						o_tx_serial_out <= 1'b1;
					end
					default:
						tx_state_r <= TX_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Smart card retry count
	// ****************************************
	// Counter saturates so a stuck card cannot wrap it back below the limit
	assign card_err_set = ctrl_r[ULS_CTL_CARD_EN] && i_card_nack
		&& (nack_cnt_r == {1'b0, ctrl_r[ULS_CTL_RETRY_LSB +: 3]}); // [R1]
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || tsr_load)
			nack_cnt_r <= 4'h0;
		else if (ctrl_r[ULS_CTL_CARD_EN] && i_card_nack && nack_cnt_r != 4'hf)
			nack_cnt_r <= nack_cnt_r + 4'h1;
	end

	// ****************************************
	// Registers, read port and interrupt
	// ****************************************
	assign irq_set = {card_err_set, tsr_load, line_err_set, push_ok};
	assign o_tx_holding_empty_irq = tx_holding_empty && ctrl_r[ULS_CTL_TX_HOLDING_EMPTY_IE]; // [R7]
	assign o_irq = (|(irq_stat_r & irq_mask_r)) || o_tx_holding_empty_irq;

	// Control, mask and write-one-to-clear status
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ctrl_r <= ULS_CTRL_RST;
			irq_mask_r <= 4'h0;
			irq_stat_r <= 4'h0;
		end
		else
		begin
			if (i_bus.wr && i_bus.addr == ULS_ADDR_CTRL)
				ctrl_r <= i_bus.wdata & ULS_CTRL_MASK;
			if (i_bus.wr && i_bus.addr == ULS_ADDR_IRQ_MASK)
				irq_mask_r <= i_bus.wdata[ULS_IRQ_W-1:0];
			// Event in the clearing cycle survives
			irq_stat_r <= (irq_stat_r & ~((i_bus.wr && i_bus.addr == ULS_ADDR_IRQ_STAT)
				? i_bus.wdata[ULS_IRQ_W-1:0] : 4'h0)) | irq_set;
		end
	end

	// Read data stands one cycle; unmapped or idle reads as zero
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !i_bus.rd)
			o_rdata <= 32'h0000_0000;
		else
		begin
			case (i_bus.addr)
				ULS_ADDR_DATA: o_rdata <= {24'h000000, head.data};
				ULS_ADDR_CTRL: o_rdata <= ctrl_r;
				ULS_ADDR_IRQ_STAT: o_rdata <= {28'h0000000, irq_stat_r};
				ULS_ADDR_IRQ_MASK: o_rdata <= {28'h0000000, irq_mask_r};
				ULS_ADDR_LINE_STATUS: o_rdata <= {23'h000000, ls_vec}; // [R19]
				default: o_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_break_frame;
		frame_done && rx_entry.bi;
	endsequence
	sequence s_bad_stop;
		frame_done && rx_entry.fe;
	endsequence

	property p_card_err;
		card_err_set && !ls_read |=> ls_vec[ULS_LS_CTE];
	endproperty
	a_card_err: assert property (p_card_err) else $error("card error flag not set"); // [R1]
	property p_rfe_set;
		ctrl_r[ULS_CTL_FIFO_EN] && push_ok && rx_entry.fe |=> rfe_r && $past(err_cnt_r) + 5'h01 == err_cnt_r
			|| $past(pop);
	endproperty
	a_rfe_set: assert property (p_rfe_set) else $error("fifo error flag missing"); // [R2]
	property p_rfe_off;
		!ctrl_r[ULS_CTL_FIFO_EN] ##1 !ctrl_r[ULS_CTL_FIFO_EN] |-> !rfe_r;
	endproperty
	a_rfe_off: assert property (p_rfe_off) else $error("fifo error flag with fifo off"); // [R3]
	property p_all_empty;
		thr_write |=> !ls_vec[ULS_LS_TAE] && !ls_vec[ULS_LS_THE];
	endproperty
	a_all_empty: assert property (p_all_empty) else $error("empty flags after write"); // [R4] [R6]
	property p_tx_holding_empty_set;
		tsr_load && !thr_write |=> tx_holding_empty ##1 !tx_all_empty;
	endproperty
	a_tx_holding_empty_set: assert property (p_tx_holding_empty_set) else $error("holding empty not set on load"); // [R5]
	property p_tx_holding_empty_irq;
		tx_holding_empty && ctrl_r[ULS_CTL_TX_HOLDING_EMPTY_IE] |-> o_tx_holding_empty_irq && o_irq;
	endproperty
	a_tx_holding_empty_irq: assert property (p_tx_holding_empty_irq) else $error("holding empty interrupt missing"); // [R7]
	property p_break;
		s_break_frame |=> rx_state_r == RX_BRK;
	endproperty
	a_break: assert property (p_break) else $error("break not entered"); // [R8]
	property p_break_idle;
		rx_state_r == RX_BRK && !rx_level_r |=> rx_state_r == RX_BRK && !push_ok;
	endproperty
	a_break_idle: assert property (p_break_idle) else $error("receiver left break early"); // [R9]
	property p_resync;
		s_bad_stop |=> rx_state_r == RX_DATA && rx_ovs_r == 4'h0;
	endproperty
	a_resync: assert property (p_resync) else $error("no resync after framing error"); // [R10] [R11]
	property p_overrun;
		frame_done && fifo_full && !pop |=> ovr_r && $stable(wr_ptr_r) && $stable(count_r);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled"); // [R14] [R15]
	property p_ls_read;
		ls_read |=> o_rdata[ULS_LS_W-1:0] == $past(ls_vec) && (!ovr_r || $past(frame_done && fifo_full));
	endproperty
	a_ls_read: assert property (p_ls_read) else $error("status read value or clear wrong"); // [R13] [R19]
	property p_head_err;
		head_new && new_head.pe |=> par_r;
	endproperty
	a_head_err: assert property (p_head_err) else $error("head parity error not shown"); // [R12] [R17] [R18]
	property p_rda;
		pop && count_r == 5'h01 && !push_ok |=> !ls_vec[ULS_LS_RDA];
	endproperty
	a_rda: assert property (p_rda) else $error("data available after last pop"); // [R16]
endmodule

// ===== logic/uls_pkg.sv
// Package of the serial line status block: register map, field positions,
// reset values, counts, state codes and carrier types.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package uls_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ULS_ADDR_DATA = 8'h00; // Read pops receive FIFO, write loads holding reg
	localparam logic [7:0] ULS_ADDR_CTRL = 8'h04; // Control and configuration
	localparam logic [7:0] ULS_ADDR_IRQ_STAT = 8'h08; // Sticky interrupt status, write one to clear
	localparam logic [7:0] ULS_ADDR_IRQ_MASK = 8'h0c; // Interrupt mask, same layout
	localparam logic [7:0] ULS_ADDR_LINE_STATUS = 8'h14; // Line status, read clears error flags; FIFO error flag only once no errored entry is left

	// ****************************************
	// Line status field positions
	// ****************************************
	localparam int ULS_LS_RDA = 0; // Receive data available
	localparam int ULS_LS_OVR = 1; // Overrun error
	localparam int ULS_LS_PAR = 2; // Parity error
	localparam int ULS_LS_FRM = 3; // Framing error
	localparam int ULS_LS_BRK = 4; // Break detect
	localparam int ULS_LS_THE = 5; // Transmit holding empty
	localparam int ULS_LS_TAE = 6; // Transmitter all empty
	localparam int ULS_LS_RFE = 7; // Receive FIFO error flag
	localparam int ULS_LS_CTE = 8; // Card transmit nack error
	localparam int ULS_LS_W = 9;
	localparam logic [8:0] ULS_LS_RST = 9'h060; // Both transmit empties start at one

	// ****************************************
	// Control field positions and reset
	// ****************************************
	localparam int ULS_CTL_FIFO_EN = 0; // FIFO enable
	localparam int ULS_CTL_PAR_EN = 1; // Parity bit present
	localparam int ULS_CTL_PAR_ODD = 2; // Odd parity when set
	localparam int ULS_CTL_CARD_EN = 3; // Smart card T=0 mode
	localparam int ULS_CTL_TX_HOLDING_EMPTY_IE = 4; // Holding empty interrupt enable
	localparam int ULS_CTL_RETRY_LSB = 8; // Card retry limit, 3 bits
	localparam int ULS_CTL_DIV_LSB = 16; // Oversample divisor, 16 bits
	localparam logic [31:0] ULS_CTRL_RST = 32'h001b_0001; // Divisor 27, FIFO on
	localparam logic [31:0] ULS_CTRL_MASK = 32'hffff_071f; // Implemented control bits

	// ****************************************
	// Interrupt status bits
	// ****************************************
	localparam int ULS_IRQ_RX = 0; // Character stored
	localparam int ULS_IRQ_LINE = 1; // Overrun, parity, framing or break flag set
	localparam int ULS_IRQ_THE = 2; // Holding register drained
	localparam int ULS_IRQ_CARD = 3; // Card transmit error
	localparam int ULS_IRQ_W = 4;

	// ****************************************
	// Counts
	// ****************************************
	localparam int ULS_FIFO_DEPTH = 16; // Receive FIFO entries
	localparam int ULS_FIFO_AW = 4; // Pointer width
	localparam logic [3:0] ULS_OVS_LAST = 4'hf; // Sixteen ticks per bit
	localparam logic [3:0] ULS_OVS_MID = 4'h7; // Middle of start bit
	localparam logic [2:0] ULS_DATA_LAST = 3'h7; // Eight data bits

	// ****************************************
	// State codes and carriers
	// ****************************************
	typedef enum logic [5:0] {
		RX_IDLE = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04,
		RX_PAR = 6'h08, RX_STOP = 6'h10, RX_BRK = 6'h20
	} uls_rx_state_t;
	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
	} uls_tx_state_t;
	typedef struct packed {
		logic bi; // Break
		logic fe; // Framing error
		logic pe; // Parity error
		logic [7:0] data; // Character
	} uls_rx_entry_t;
	typedef struct packed {
		logic [7:0] addr; // Byte address
		logic [31:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} uls_bus_req_t;
endpackage

// ===== verif/testbench.sv
// Self-checking bench of the line status block with a remote serial partner.
// Assumes divisor 1, so one bit lasts 16 clocks.
`timescale 1ns/10ps
module testbench;
	logic i_clk;
	logic i_sys_rst;
	uls_pkg::uls_bus_req_t bus;
	logic [31:0] rdata;
	logic rx_line, tx_line, nack, tx_holding_empty_irq, irq, rd_d;
	logic [7:0] rx_byte;
	logic [31:0] expq[$]; // Expected read data, oldest first
	logic [7:0] ch[17];
	int errors, comparisons, seed;
	uls_line_status DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
		.i_rx_serial_in(rx_line), .o_tx_serial_out(tx_line), .i_card_nack(nack),
		.o_tx_holding_empty_irq(tx_holding_empty_irq), .o_irq(irq));
	uls_remote remote (.i_clk(i_clk), .i_tx_line(tx_line), .o_rx_line(rx_line), .o_byte(rx_byte));
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge i_clk);
		bus.wr <= 1'b0;
	endtask
	// Read: note the expected word, the watcher compares it a cycle later
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		expq.push_back(e);
		@(posedge i_clk);
		bus.rd <= 1'b0;
	endtask
	task automatic feed(input logic [11:0] bits, input int n, input int w);
		remote.send(bits, n);
		repeat (w) @(posedge i_clk);
	endtask
	task automatic pulse_nack;
		@(posedge i_clk);
		nack <= 1'b1;
		@(posedge i_clk);
		nack <= 1'b0;
	endtask
	// Watcher: read data stand only in the cycle after the strobe
	always @(posedge i_clk)
	begin
		if (rd_d === 1'b1)
			check(rdata, expq.pop_front(), "read data");
		rd_d <= bus.rd;
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge i_clk);
		errors++;
		complete_run();
	end
	initial
	begin
		seed = 28;
		errors = 0;
		comparisons = 0;
		rd_d = 1'b0;
		bus = '0;
		nack = 1'b0;
		i_sys_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(8'h14, 32'h60);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'h0001_0003);
		// Let the divider run out its reset count and pick up the new divisor
		repeat (40) @(posedge i_clk);
		ch[0] = $random(seed);
		feed({1'b1, ^ch[0], ch[0], 1'b0}, 11, 40);
		rd(8'h14, 32'h61);
		rd(8'h00, {24'h0, ch[0]});
		rd(8'h14, 32'h60);
		feed({1'b1, ~^ch[0], ch[0], 1'b0}, 11, 40);
		rd(8'h14, 32'he5);
		rd(8'h14, 32'he1);
		rd(8'h00, {24'h0, ch[0]});
		rd(8'h14, 32'he0);
		rd(8'h14, 32'h60);
		wr(8'h04, 32'h0001_0001);
		feed({1'b0, ch[0], 1'b0}, 10, 200);
		rd(8'h14, 32'he9);
		rd(8'h00, {24'h0, ch[0]});
		rd(8'h00, 32'hff);
		rd(8'h14, 32'he0);
		rd(8'h14, 32'h60);
		feed(12'h000, 12, 40);
		rd(8'h14, 32'hf1);
		rd(8'h00, 32'h0);
		rd(8'h14, 32'he0);
		rd(8'h14, 32'h60);
		for (int i = 0; i < 17; i++)
		begin
			ch[i] = $random(seed);
			feed({1'b1, ch[i], 1'b0}, 10, 0);
		end
		repeat (40) @(posedge i_clk);
		rd(8'h14, 32'h63);
		for (int i = 0; i < 16; i++)
			rd(8'h00, {24'h0, ch[i]});
		rd(8'h14, 32'h60);
		wr(8'h04, 32'h0001_0002);
		feed({1'b1, ~^ch[3], ch[3], 1'b0}, 11, 40);
		rd(8'h14, 32'h65);
		rd(8'h00, {24'h0, ch[3]});
		rd(8'h14, 32'h60);
		wr(8'h04, 32'h0001_0001);
		wr(8'h08, 32'hf);
		wr(8'h0c, 32'h0);
		wr(8'h00, {24'h0, ch[1]});
		repeat (2) @(posedge i_clk);
		rd(8'h14, 32'h20);
		@(negedge i_clk);
		check(irq, 1'b0, "masked irq");
		wr(8'h0c, 32'h4);
		@(negedge i_clk);
		check(irq, 1'b1, "irq");
		wr(8'h08, 32'h4);
		@(negedge i_clk);
		check(irq, 1'b0, "cleared irq");
		repeat (200) @(posedge i_clk);
		check(rx_byte, ch[1], "tx byte");
		rd(8'h14, 32'h60);
		wr(8'h04, 32'h0001_0011);
		@(negedge i_clk);
		check(tx_holding_empty_irq, 1'b1, "tx_holding_empty irq");
		wr(8'h04, 32'h0001_0109);
		wr(8'h00, {24'h0, ch[2]});
		repeat (2) @(posedge i_clk);
		rd(8'h14, 32'h20);
		pulse_nack();
		rd(8'h14, 32'h20);
		pulse_nack();
		rd(8'h14, 32'h120);
		repeat (200) @(posedge i_clk);
		rd(8'h14, 32'h60);
		repeat (4) @(posedge i_clk);
		complete_run();
	end
endmodule

// ===== verif/uls_remote.sv
// Remote serial partner: drives the receive line and decodes the transmit line.
// Assumes 16 clocks per bit (divisor 1), 8 data bits, no parity on transmit.
`timescale 1ns/10ps
module uls_remote (
	input wire logic i_clk,
	input wire logic i_tx_line,
	output logic o_rx_line,
	output logic [7:0] o_byte
);
	// Line idles high between frames
	initial o_rx_line = 1'b1;
	initial o_byte = 8'h00;
	// Send n bits LSB first, one bit per 16 clocks, then idle high
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge i_clk);
			o_rx_line <= bits[i];
			repeat (15) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_rx_line <= 1'b1;
	endtask
	// Decode: find start edge, sample mid bit, shift in LSB first
	always
	begin
		@(negedge i_tx_line);
		repeat (8) @(posedge i_clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (16) @(posedge i_clk);
			if (i < 8)
				o_byte = {i_tx_line, o_byte[7:1]};
		end
	end
endmodule
